// File: include/supervisor_pkg.sv
// constants, register map and types of the supervisor timing core
// Overview of operation
// - ready within 12 ms with self-test
// - ready within 2 ms without self-test
// - bus accepts traffic right after self-test
// - timestamp restarts on pin edge, 50us steps
// - monitoring active within 10 us of run
// - other faults raise interrupt within 25 us
// - other faults raise reset within 25 us
// - fast faults reach outputs within 650/750 ns
// - 3-bit code selects reset hold time
// - debounce programmable from 0.1 to 102.4 us
package supervisor_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_US = 1000;
    // printed limits
    localparam int READY_BIST_MS = 12;
    localparam int READY_NBIST_MS = 2;
    localparam int SELFTEST_MAX_MS = 10;
    localparam int BUS_AFTER_TEST_US = 0;
    localparam int SEQ_LSB_US = 50;
    localparam int SEQ_RANGE_S = 4;
    localparam int MON_ACT_MAX_US = 10;
    localparam int OTHER_FAULT_MAX_US = 25;
    localparam int FAST_1X_MAX_NS = 650;
    localparam int FAST_4X_MAX_NS = 750;
    localparam int DEB_STEP_NS = 100;
    localparam int DEB_MAX_NS = 102400;
    // chosen phase lengths; load alone fits the 2 ms ready limit, load plus test the 12 ms one
    localparam int LOAD_US = 1000;
    localparam int TEST_US = 9000;
    localparam int LOAD_CYCLES = LOAD_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int TEST_CYCLES = TEST_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int SEQ_LSB_CYCLES = SEQ_LSB_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int SEQ_MAX = SEQ_RANGE_S * 1000000 / SEQ_LSB_US;
    localparam int DEB_STEP_CYCLES = DEB_STEP_NS / CLK_PERIOD_NS;
    localparam int DEB_CODES = DEB_MAX_NS / DEB_STEP_NS;
    localparam int HOLD_UNIT_CYCLES = NS_PER_US / CLK_PERIOD_NS;
    localparam int CNT_W = 24;
    localparam int SEQ_W = 17;
    localparam int HOLD_W = 18;
    localparam int DEB_W = 10;
    localparam int CHANNELS = 8;
    // register byte addresses
    localparam logic [5:0] ADDR_CTRL = 6'h00;
    localparam logic [5:0] ADDR_DEBOUNCE = 6'h04;
    localparam logic [5:0] ADDR_STATUS = 6'h08;
    localparam logic [5:0] ADDR_MASK = 6'h0C;
    localparam logic [5:0] ADDR_STAMP = 6'h10;
    localparam logic [5:0] ADDR_STATE = 6'h14;
    // control fields
    localparam int CTRL_DELAY_LSB = 0;
    localparam int CTRL_SDTEST_BIT = 4;
    localparam logic [2:0] DELAY_RST = 3'h0;
    localparam logic SDTEST_RST = 1'b0;
    localparam logic [DEB_W-1:0] DEB_RST = 10'h003;
    // status and mask layout
    localparam int STATUS_W = 4;
    localparam int ST_READY = 0;
    localparam int ST_FAST = 1;
    localparam int ST_OTHER = 2;
    localparam int ST_STAMP = 3;
    localparam logic [STATUS_W-1:0] MASK_RST = 4'h6;
    typedef enum logic [4:0] {
        S_LOAD = 5'b00001,
        S_TEST = 5'b00010,
        S_IDLE = 5'b00100,
        S_ACTIVE = 5'b01000,
        S_SDTEST = 5'b10000
    } boot_state_t;
    // hold time in microsecond units per delay code
    function automatic logic [HOLD_W-1:0] hold_units(input logic [2:0] code);
        case (code)
            3'h0: hold_units = 18'h000C8;
            3'h1: hold_units = 18'h003E8;
            3'h2: hold_units = 18'h02710;
            3'h3: hold_units = 18'h03E80;
            3'h4: hold_units = 18'h04E20;
            3'h5: hold_units = 18'h11170;
            3'h6: hold_units = 18'h186A0;
            default: hold_units = 18'h30D40;
        endcase
    endfunction
endpackage

// File: rtl/tick_divider.sv
// divider giving a one-cycle enable pulse every DIV clocks
`timescale 1ns/100ps
module tick_divider #(
    parameter int DIV = 10
) (
    input wire logic mclk, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic clear, // restart the period
    output logic tick // one-cycle pulse
);
    logic [23:0] cnt;
    logic [23:0] next_cnt;
    logic next_tick;

    always_comb begin
        next_cnt = cnt + 24'h000001;
        next_tick = 1'b0;
        if (clear) begin
            next_cnt = 24'h000000;
        end else if (cnt == 24'(DIV - 1)) begin
            next_cnt = 24'h000000;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 24'h000000;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule

// File: rtl/supervisor_timing_core.sv
// boot sequencing, fault timing, reset hold and registers of the supervisor
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
module supervisor_timing_core
    import supervisor_pkg::*;
#(
    parameter int LOAD_CYC = LOAD_CYCLES,
    parameter int TEST_CYC = TEST_CYCLES,
    parameter int SEQ_LSB_CYC = SEQ_LSB_CYCLES,
    parameter int HOLD_UNIT_CYC = HOLD_UNIT_CYCLES
) (
    input wire logic mclk, // system clock, 100 MHz
    input wire logic resetn, // power-on reset, active low
    input wire logic [5:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    input wire logic selftest_on_powerup, // strap: run self-test at boot
    input wire logic run_request_pin, // run request
    input wire logic sleep_pin, // sleep request
    input wire logic [CHANNELS-1:0] fast_fault_in, // comparator trips
    input wire logic other_fault_in, // non-threshold fault
    input wire logic fault_interrupt_out_in, // pin level readback
    output logic fault_interrupt_out_o, // pin output value
    output logic fault_interrupt_out_oe_n, // low while pulled down
    input wire logic supervisor_reset_out_in, // pin level readback
    output logic supervisor_reset_out_o, // pin output value
    output logic supervisor_reset_out_oe_n, // low while pulled down
    output logic irq, // level interrupt
    output logic ready, // boot finished
    output logic monitor_active // monitoring running
);
    boot_state_t state;
    boot_state_t next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic strap;
    logic next_strap;
    logic next_ready;
    logic next_monitor;
    logic run_prev;
    logic sleep_prev;
    logic run_rise;
    logic run_fall;
    logic pin_edge;
    logic deb_tick;
    logic seq_tick;
    logic hold_tick;

    // control registers
    logic [2:0] delay_code;
    logic [2:0] next_delay_code;
    logic sdtest_en;
    logic next_sdtest_en;
    logic [DEB_W-1:0] deb_code;
    logic [DEB_W-1:0] next_deb_code;
    logic [STATUS_W-1:0] status;
    logic [STATUS_W-1:0] next_status;
    logic [STATUS_W-1:0] mask;
    logic [STATUS_W-1:0] next_mask;
    logic next_irq;

    // bus
    logic req;
    logic accept;
    logic next_wait;
    logic [31:0] next_rdata;
    logic [31:0] rmux;

    // faults and reset
    logic [CHANNELS-1:0] fast_flt;
    logic other_q;
    logic next_other;
    logic rst_cond;
    logic rst_active;
    logic next_rst_active;
    logic [HOLD_W-1:0] hold_cnt;
    logic [HOLD_W-1:0] next_hold_cnt;

    // timestamp
    logic [SEQ_W-1:0] stamp;
    logic [SEQ_W-1:0] next_stamp;
    logic stamp_run;
    logic next_stamp_run;
    logic stamp_sat;

    assign run_rise = run_request_pin & ~run_prev;
    assign run_fall = ~run_request_pin & run_prev;
    assign pin_edge = (run_request_pin ^ run_prev) | (sleep_pin ^ sleep_prev);
    assign req = avs_read | avs_write;
    assign accept = req & ~avs_waitrequest;

    tick_divider #(.DIV(DEB_STEP_CYCLES)) u_deb_div (
        .mclk(mclk),
        .resetn(resetn),
        .clear(1'b0),
        .tick(deb_tick)
    );

    tick_divider #(.DIV(SEQ_LSB_CYC)) u_seq_div (
        .mclk(mclk),
        .resetn(resetn),
        .clear(pin_edge),
        .tick(seq_tick)
    );

    // hold period starts counting when the reset cause clears
    tick_divider #(.DIV(HOLD_UNIT_CYC)) u_hold_div (
        .mclk(mclk),
        .resetn(resetn),
        .clear(rst_cond),
        .tick(hold_tick)
    );

    // boot and run sequencing
    always_comb begin
        next_state = state;
        next_cnt = cnt + 24'h000001;
        next_strap = strap;
        case (state)
            S_LOAD: begin
                // strap caught after reset release
                if (cnt == 24'h000000) begin
                    next_strap = selftest_on_powerup;
                end
                if (cnt == 24'(LOAD_CYC - 1)) begin
                    next_cnt = 24'h000000;
                    next_state = strap ? S_TEST : S_IDLE;
                end
            end
            S_TEST: begin
                if (cnt == 24'(TEST_CYC - 1)) begin
                    next_cnt = 24'h000000;
                    next_state = S_IDLE;
                end
            end
            S_IDLE: begin
                next_cnt = 24'h000000;
                if (run_rise) begin
                    next_state = S_ACTIVE;
                end
            end
            S_ACTIVE: begin
                next_cnt = 24'h000000;
                if (run_fall) begin
                    next_state = sdtest_en ? S_SDTEST : S_IDLE;
                end
            end
            S_SDTEST: begin
                if (cnt == 24'(TEST_CYC - 1)) begin
                    next_cnt = 24'h000000;
                    next_state = S_IDLE;
                end
            end
            default: begin
                next_cnt = 24'h000000;
                next_state = S_LOAD;
            end
        endcase
        next_ready = (next_state == S_IDLE) | (next_state == S_ACTIVE);
        next_monitor = (next_state == S_ACTIVE);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= S_LOAD;
            cnt <= 24'h000000;
            strap <= 1'b0;
            ready <= 1'b0;
            monitor_active <= 1'b0;
            run_prev <= 1'b0;
            sleep_prev <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            strap <= next_strap;
            ready <= next_ready;
            monitor_active <= next_monitor;
            run_prev <= run_request_pin;
            sleep_prev <= sleep_pin;
        end
    end

    // per-channel debounce: a trip must persist deb_code+1 steps of 0.1 us
    generate
        for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_deb
            logic [DEB_W-1:0] dcnt;
            logic [DEB_W-1:0] next_dcnt;
            logic next_flt;

            always_comb begin
                next_dcnt = dcnt;
                next_flt = fast_flt[ch];
                if (!monitor_active || !fast_fault_in[ch]) begin
                    next_dcnt = '0;
                    next_flt = 1'b0;
                end else if (deb_tick && !fast_flt[ch]) begin
                    if (dcnt == deb_code) begin
                        next_flt = 1'b1;
                    end else begin
                        next_dcnt = dcnt + 10'h001;
                    end
                end
            end

            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    dcnt <= '0;
                    fast_flt[ch] <= 1'b0;
                end else begin
                    dcnt <= next_dcnt;
                    fast_flt[ch] <= next_flt;
                end
            end
        end
    endgenerate

    // reset output with hold after the cause clears
    assign rst_cond = ~ready | (|fast_flt) | other_q;

    always_comb begin
        next_other = other_fault_in & ready;
        next_hold_cnt = hold_cnt;
        next_rst_active = rst_active;
        if (rst_cond) begin
            next_hold_cnt = '0;
            next_rst_active = 1'b1;
        end else if (rst_active && hold_tick) begin
            if (hold_cnt == hold_units(delay_code) - 18'h00001) begin
                next_rst_active = 1'b0;
                next_hold_cnt = '0;
            end else begin
                next_hold_cnt = hold_cnt + 18'h00001;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            other_q <= 1'b0;
            hold_cnt <= '0;
            rst_active <= 1'b1;
            supervisor_reset_out_o <= 1'b0;
            supervisor_reset_out_oe_n <= 1'b0;
        end else begin
            other_q <= next_other;
            hold_cnt <= next_hold_cnt;
            rst_active <= next_rst_active;
            supervisor_reset_out_o <= 1'b0;
            supervisor_reset_out_oe_n <= ~next_rst_active;
        end
    end

    // sequence timestamp, saturates at the range end
    assign stamp_sat = stamp_run & seq_tick & (stamp == 17'(SEQ_MAX - 1));

    always_comb begin
        next_stamp = stamp;
        next_stamp_run = stamp_run;
        if (pin_edge) begin
            next_stamp = '0;
            next_stamp_run = 1'b1;
        end else if (stamp_run && seq_tick) begin
            next_stamp = stamp + 17'h00001;
            if (stamp == 17'(SEQ_MAX - 1)) begin
                next_stamp_run = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            stamp <= '0;
            stamp_run <= 1'b0;
        end else begin
            stamp <= next_stamp;
            stamp_run <= next_stamp_run;
        end
    end

    // register read mux; unmapped addresses read zero
    always_comb begin
        rmux = 32'h00000000;
        case (avs_address)
            ADDR_CTRL: begin
                rmux[CTRL_DELAY_LSB +: 3] = delay_code;
                rmux[CTRL_SDTEST_BIT] = sdtest_en;
            end
            ADDR_DEBOUNCE: rmux[DEB_W-1:0] = deb_code;
            ADDR_STATUS: rmux[STATUS_W-1:0] = status;
            ADDR_MASK: rmux[STATUS_W-1:0] = mask;
            ADDR_STAMP: rmux[SEQ_W-1:0] = stamp;
            ADDR_STATE: rmux[11:0] = {fault_interrupt_out_in, supervisor_reset_out_in,
                rst_active, monitor_active, ready, strap, 1'b0, state};
            default: rmux = 32'h00000000;
        endcase
    end

    // bus slave and register updates
    always_comb begin
        // stalls until the core is ready; answers one cycle after a request
        next_wait = 1'b1;
        if (!accept && req && avs_waitrequest && ready) begin
            next_wait = 1'b0;
        end
        next_rdata = avs_readdata;
        if (!next_wait) begin
            next_rdata = rmux;
        end
        next_delay_code = delay_code;
        next_sdtest_en = sdtest_en;
        next_deb_code = deb_code;
        next_mask = mask;
        next_status = status;
        if (accept && avs_write) begin
            if (avs_address == ADDR_CTRL && avs_byteenable[0]) begin
                next_delay_code = avs_writedata[CTRL_DELAY_LSB +: 3];
                next_sdtest_en = avs_writedata[CTRL_SDTEST_BIT];
            end
            if (avs_address == ADDR_DEBOUNCE) begin
                if (avs_byteenable[0]) begin
                    next_deb_code[7:0] = avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    next_deb_code[9:8] = avs_writedata[9:8];
                end
            end
            if (avs_address == ADDR_MASK && avs_byteenable[0]) begin
                next_mask = avs_writedata[STATUS_W-1:0];
            end
        end
        if (accept && avs_read && avs_address == ADDR_STATUS) begin
            next_status = '0;
        end
        // new events win over the read-clear in the same cycle
        next_status[ST_READY] = next_status[ST_READY] | (next_ready & ~ready);
        next_status[ST_FAST] = next_status[ST_FAST] | (|fast_flt);
        next_status[ST_OTHER] = next_status[ST_OTHER] | other_q;
        next_status[ST_STAMP] = next_status[ST_STAMP] | stamp_sat;
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
            delay_code <= DELAY_RST;
            sdtest_en <= SDTEST_RST;
            deb_code <= DEB_RST;
            mask <= MASK_RST;
            status <= '0;
            irq <= 1'b0;
            fault_interrupt_out_o <= 1'b0;
            fault_interrupt_out_oe_n <= 1'b1;
        end else begin
            avs_waitrequest <= next_wait;
            avs_readdata <= next_rdata;
            delay_code <= next_delay_code;
            sdtest_en <= next_sdtest_en;
            deb_code <= next_deb_code;
            mask <= next_mask;
            status <= next_status;
            irq <= next_irq;
            fault_interrupt_out_o <= 1'b0;
            fault_interrupt_out_oe_n <= ~next_irq;
        end
    end
endmodule

// File: dv/od_pullup_pin.sv
// pulled-up open-drain pin as the host system sees it
`timescale 1ns/100ps
module od_pullup_pin (
    input wire logic oe_n, // low while the core pulls down
    input wire logic o, // level driven when enabled
    output logic pin // resolved wire level
);
    // released pin is pulled up
    assign pin = oe_n ? 1'h1 : o;
endmodule

// File: dv/supervisor_timing_core_asserts.sv
// port assertions for the supervisor timing core
`timescale 1ns/100ps
module supervisor_timing_core_asserts
    import supervisor_pkg::*;
#(
    parameter int LOAD_CYC = LOAD_CYCLES,
    parameter int TEST_CYC = TEST_CYCLES,
    parameter int HOLD_UNIT_CYC = HOLD_UNIT_CYCLES
) (
    input wire logic mclk, // clock
    input wire logic resetn, // reset, active low
    input wire logic [5:0] avs_address, // bus address
    input wire logic avs_read, // read
    input wire logic avs_write, // write
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // lanes
    input wire logic avs_waitrequest, // stall
    input wire logic selftest_on_powerup, // strap
    input wire logic run_request_pin, // run
    input wire logic [CHANNELS-1:0] fast_fault_in, // trips
    input wire logic other_fault_in, // other fault
    input wire logic fault_interrupt_out_oe_n, // irq pin enable
    input wire logic supervisor_reset_out_oe_n, // reset pin enable
    input wire logic ready, // boot done
    input wire logic monitor_active // monitoring
);
    int low_cnt, fast_cnt, hold_cnt;
    logic booted, cause;
    logic [9:0] deb_q;
    logic [2:0] code_q;
    // mirrors bus writes so limits follow the codes
    assign cause = !ready || other_fault_in || (monitor_active && |fast_fault_in);
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            low_cnt <= 0;
            fast_cnt <= 0;
            hold_cnt <= 0;
            booted <= 1'h0;
            deb_q <= DEB_RST;
            code_q <= DELAY_RST;
        end else begin
            low_cnt <= ready ? 0 : low_cnt + 1;
            booted <= booted | ready;
            fast_cnt <= (monitor_active && |fast_fault_in) ? fast_cnt + 1 : 0;
            hold_cnt <= cause ? 0 : hold_cnt + 1;
            if (avs_write && !avs_waitrequest) begin
                if (avs_address == ADDR_DEBOUNCE && avs_byteenable[0]) deb_q[7:0] <= avs_writedata[7:0];
                if (avs_address == ADDR_DEBOUNCE && avs_byteenable[1]) deb_q[9:8] <= avs_writedata[9:8];
                if (avs_address == ADDR_CTRL && avs_byteenable[0]) code_q <= avs_writedata[2:0];
            end
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    chk_ready_time: assert property (!booted && !ready |-> low_cnt <= LOAD_CYC + (selftest_on_powerup ? TEST_CYC : 0) + 2)
        else $error("late ready");
    chk_selftest_len: assert property (booted && !ready |-> low_cnt <= TEST_CYC + 2)
        else $error("long self-test");
    chk_bus_answer: assert property (ready && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no bus answer");
    chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("long answer");
    chk_monitor_start: assert property (ready && !monitor_active && $rose(run_request_pin) |-> ##[1:3] monitor_active)
        else $error("late monitor");
    chk_other_irq: assert property (ready && other_fault_in |-> ##[1:3] !fault_interrupt_out_oe_n)
        else $error("late irq pin");
    chk_other_reset: assert property (ready && other_fault_in |-> ##[1:3] !supervisor_reset_out_oe_n)
        else $error("late reset pin");
    chk_fast_reset: assert property (fast_cnt == (deb_q + 1) * DEB_STEP_CYCLES + DEB_STEP_CYCLES + 4 |-> !supervisor_reset_out_oe_n)
        else $error("late fast reset");
    chk_hold_time: assert property ($rose(supervisor_reset_out_oe_n) |-> hold_cnt >= hold_units(code_q) * HOLD_UNIT_CYC - HOLD_UNIT_CYC && hold_cnt <= hold_units(code_q) * HOLD_UNIT_CYC + HOLD_UNIT_CYC + 4)
        else $error("bad hold time");
    chk_reset_boot: assert property (!ready ##1 !ready |-> !supervisor_reset_out_oe_n)
        else $error("reset off unready");
endmodule
bind supervisor_timing_core supervisor_timing_core_asserts #(.LOAD_CYC(LOAD_CYC), .TEST_CYC(TEST_CYC),
    .HOLD_UNIT_CYC(HOLD_UNIT_CYC)) u_chk (.*);

// File: dv/supervisor_timing_core_tb.sv
// self-checking bench for the supervisor timing core
`timescale 1ns/100ps
module supervisor_timing_core_tb;
    import supervisor_pkg::*;
    localparam int LC = 20;
    localparam int TC = 30;
    localparam int HC = 2;
    localparam int LIM = 30000;
    logic mclk = 1'h0;
    logic resetn = 1'h0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'h0, avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata, q;
    logic strap = 1'h1, run_pin = 1'h0, sleep_pin = 1'h0, other_in = 1'h0;
    logic [7:0] fast_in = 8'h00;
    logic avs_waitrequest, irq_o, irq_oe_n, rst_o, rst_oe_n, irq_pin, rst_pin, irq, ready, mon;
    logic [3:0] watch;
    int n, err_total = 0, cmp_count = 0;
    assign watch = {ready, mon, rst_pin, irq_pin};
    supervisor_timing_core #(.LOAD_CYC(LC), .TEST_CYC(TC), .SEQ_LSB_CYC(8), .HOLD_UNIT_CYC(HC)) dut (
        .mclk(mclk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .selftest_on_powerup(strap), .run_request_pin(run_pin), .sleep_pin(sleep_pin),
        .fast_fault_in(fast_in), .other_fault_in(other_in), .fault_interrupt_out_in(irq_pin),
        .fault_interrupt_out_o(irq_o), .fault_interrupt_out_oe_n(irq_oe_n),
        .supervisor_reset_out_in(rst_pin), .supervisor_reset_out_o(rst_o),
        .supervisor_reset_out_oe_n(rst_oe_n), .irq(irq), .ready(ready), .monitor_active(mon));
    od_pullup_pin irq_wire (.oe_n(irq_oe_n), .o(irq_o), .pin(irq_pin));
    od_pullup_pin rst_wire (.oe_n(rst_oe_n), .o(rst_o), .pin(rst_pin));
    initial begin
        forever #5 mclk = ~mclk;
    end
    task automatic report_and_stop();
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic timeout();
        err_total++;
        $display("wrong value at %0t: timeout", $time);
        report_and_stop();
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [31:0] got, input int lo, input int hi, input string msg);
        cmp_count++;
        if ($isunknown(got) || got < lo || got > hi) begin
            err_total++;
            $display("wrong value at %0t: %s %0d not in %0d..%0d", $time, msg, got, lo, hi);
        end
    endtask
    // held until waitrequest low, then idle a cycle
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < LIM);
        q = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        if (n >= LIM) timeout();
        @(posedge mclk);
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp, input string msg);
        bus(1'h0, a, 32'h00000000);
        chk_val(q, exp, msg);
    endtask
    task automatic wait_bit(input int b, input logic v);
        n = 0;
        while (watch[b] !== v && n < LIM) begin
            @(posedge mclk);
            n++;
        end
        if (n >= LIM) timeout();
    endtask
    task automatic hold(input int k);
        repeat (k) @(posedge mclk);
    endtask
    initial begin
        hold(2);
        resetn <= 1'h1;
        bus(1'h0, ADDR_STATE, 32'h00000000);
        chk_rng(n, LC + TC + 1, LC + TC + 5, "boot");
        chk_val(q, 32'h00000AC4, "state");
        rd_chk(ADDR_CTRL, 32'h00000000, "ctrl");
        rd_chk(ADDR_DEBOUNCE, 32'h00000003, "deb");
        rd_chk(ADDR_MASK, 32'h00000006, "mask");
        rd_chk(ADDR_STATUS, 32'h00000001, "rdy ev");
        rd_chk(ADDR_STATUS, 32'h00000000, "clr");
        bus(1'h1, 6'h3C, 32'hFFFFFFFF);
        rd_chk(6'h3C, 32'h00000000, "unmap");
        wait_bit(1, 1'h1);
        chk_rng(n, 360, 405, "boot hold");
        run_pin <= 1'h1;
        wait_bit(2, 1'h1);
        chk_rng(n, 1, 4, "mon");
        hold(80);
        bus(1'h0, ADDR_STAMP, 32'h00000000);
        chk_rng(q, 9, 12, "stamp run");
        sleep_pin <= 1'h1;
        hold(16);
        bus(1'h0, ADDR_STAMP, 32'h00000000);
        chk_rng(q, 1, 3, "stamp slp");
        // glitch below the default filter
        fast_in <= 8'h20;
        hold(25);
        fast_in <= 8'h00;
        hold(5);
        chk_val(rst_pin, 1'h1, "glitch");
        fast_in <= 8'h20;
        wait_bit(1, 1'h0);
        chk_rng(n, 31, 65, "fast rst");
        wait_bit(0, 1'h0);
        chk_rng(n, 0, 1, "fast irq");
        fast_in <= 8'h00;
        wait_bit(1, 1'h1);
        chk_rng(n, 398, 406, "flt hold");
        chk_val({irq, irq_pin}, 32'h00000002, "sticky");
        rd_chk(ADDR_STATUS, 32'h00000002, "fast st");
        hold(2);
        chk_val({irq, irq_pin}, 32'h00000001, "irq clr");
        bus(1'h1, ADDR_MASK, 32'h00000000);
        fast_in <= 8'h01;
        wait_bit(1, 1'h0);
        hold(3);
        chk_val({irq, irq_pin}, 32'h00000001, "masked");
        fast_in <= 8'h00;
        rd_chk(ADDR_STATUS, 32'h00000002, "mask st");
        bus(1'h1, ADDR_MASK, 32'h00000006);
        bus(1'h1, ADDR_DEBOUNCE, 32'h00000000);
        wait_bit(1, 1'h1);
        fast_in <= 8'h80;
        wait_bit(1, 1'h0);
        chk_rng(n, 1, 25, "min filt");
        fast_in <= 8'h00;
        bus(1'h1, ADDR_DEBOUNCE, 32'h000003FF);
        rd_chk(ADDR_DEBOUNCE, 32'h000003FF, "max code");
        wait_bit(1, 1'h1);
        fast_in <= 8'h01;
        hold(10000);
        chk_val(rst_pin, 1'h1, "filt held");
        wait_bit(1, 1'h0);
        chk_rng(n, 200, 270, "max filt");
        fast_in <= 8'h00;
        bus(1'h1, ADDR_DEBOUNCE, 32'h00000003);
        wait_bit(1, 1'h1);
        rd_chk(ADDR_STATUS, 32'h00000002, "pre oth");
        other_in <= 1'h1;
        wait_bit(0, 1'h0);
        chk_rng(n, 1, 3, "oth irq");
        chk_val(rst_pin, 1'h0, "oth rst");
        other_in <= 1'h0;
        hold(4);
        rd_chk(ADDR_STATUS, 32'h00000004, "oth st");
        wait_bit(1, 1'h1);
        for (int c = 0; c < 8; c++) begin
            bus(1'h1, ADDR_CTRL, 32'(c));
            rd_chk(ADDR_CTRL, 32'(c), "code");
            // longer holds exceed the run budget
            if (c < 3) begin
                other_in <= 1'h1;
                hold(4);
                other_in <= 1'h0;
                wait_bit(1, 1'h1);
                chk_rng(n, hold_units(3'(c)) * HC - HC, hold_units(3'(c)) * HC + HC + 6, "hold");
                rd_chk(ADDR_STATUS, 32'h00000004, "hold st");
            end
        end
        bus(1'h1, ADDR_CTRL, 32'h00000010);
        run_pin <= 1'h0;
        wait_bit(3, 1'h0);
        wait_bit(3, 1'h1);
        chk_rng(n, TC - 2, TC + 4, "sd test");
        chk_val(mon, 1'h0, "mon off");
        strap <= 1'h0;
        resetn <= 1'h0;
        hold(2);
        resetn <= 1'h1;
        wait_bit(3, 1'h1);
        chk_rng(n, LC, LC + 3, "boot nt");
        report_and_stop();
    end
endmodule
